/* File: ctp_pkg.sv */
/*
 * Shared constants and types for the camera-serial transmit port control.
 * Assumes an 8-bit register port fed by the host serial control port logic.
 */
package ctp_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] CTP_OFS_PORT_SELECT = 8'h32;
	localparam logic [7:0] CTP_OFS_OUTPUT_CTRL = 8'h33;
	localparam logic [7:0] CTP_OFS_CALIB_CTRL = 8'h34;
	localparam logic [7:0] CTP_RST_PORT_SELECT = 8'h00;
	localparam logic [7:0] CTP_RST_OUTPUT_CTRL = 8'h00;
	localparam logic [7:0] CTP_RST_CALIB_CTRL = 8'h00;
	// Writable bit masks; other bits are reserved and read zero
	localparam logic [7:0] CTP_MSK_PORT_SELECT = 8'h01;
	localparam logic [7:0] CTP_MSK_OUTPUT_CTRL = 8'h7F;
	localparam logic [7:0] CTP_MSK_CALIB_CTRL = 8'h3F;
	// ==========================================================
	// Field positions
	localparam int CTP_BIT_WRITE_PORT0 = 0;
	localparam int CTP_BIT_OUT_ENABLE = 0;
	localparam int CTP_BIT_CONT_CLOCK = 1;
	localparam int CTP_POS_FORCED_STOP = 2;
	localparam int CTP_POS_LANE_COUNT = 4;
	localparam int CTP_BIT_INIT_CAL = 6;
	localparam int CTP_BIT_CAL_PERIODIC = 0;
	localparam int CTP_BIT_CAL_SINGLE = 1;
	localparam int CTP_BIT_PATTERN_INV = 2;
	localparam int CTP_BIT_PASS_MODE = 3;
	localparam int CTP_POS_CAL_LEN = 4;
	// ==========================================================
	// Field codes and sequence lengths in bits
	localparam logic [1:0] CTP_STOP_NORMAL = 2'h0;
	localparam logic [1:0] CTP_STOP_DATA = 2'h1;
	localparam logic [1:0] CTP_STOP_ALL = 2'h3;
	localparam logic [15:0] CTP_CAL_LEN_0 = 16'h0400;
	localparam logic [15:0] CTP_CAL_LEN_1 = 16'h1000;
	localparam logic [15:0] CTP_CAL_LEN_2 = 16'h4000;
	localparam logic [15:0] CTP_CAL_LEN_3 = 16'h8000;
	localparam int CTP_NUM_RX = 4;
	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		CTP_ST_OFF = 4'h1,
		CTP_ST_INIT = 4'h2,
		CTP_ST_RUN = 4'h4,
		CTP_ST_CAL = 4'h8
	} ctp_state_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ctp_reg_req_t;
endpackage

/* File: ctp_tx_port_ctrl.sv */
/*
 * Transmit port control: port select, output control and calibration
 * control registers, lane and stop-state selection, continuous clock,
 * skew-calibration sequencer and pass indication.
 * Assumes the register port and event strobes share clk_i; receive-port
 * valid flags and the lane bit clock come from other domains.
 */
// Notes on behaviour
// - Port-specific registers take writes only while port 0 write enable is set.
// - One write updates every enabled transmit port copy at once.
// - Initial calibration enabled sends a skew sequence before any high-speed data.
// - Lane-count code 00,01,10,11 gives four, three, two, one lanes.
// - Stop code 01 forces LP00 on data, 11 on data and clock.
// - Continuous clock starts only after the first packet is sent.
// - Output driven only while output enable bit is one.
// - Periodic length code gives 1024, 4096, 16384 or 32768 bits.
// - Pass mode zero means any enabled port valid, one means all.
// - Skew pattern alternates starting with 0, inverted when invert bit set.
// - Single-calibration write sends one periodic-length sequence at next idle.
// - Single-calibration bit clears itself once its sequence is sent.
// - Periodic calibration sends a sequence after each Frame End.
// - Pass shows active valid delivery and clears on transmission error.
`timescale 1ns/1ns
module ctp_tx_port_ctrl
	import ctp_pkg::*;
#(
	parameter int CAL_LEN_SHIFT = 0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Register port
	input wire ctp_reg_req_t reg_req_i,
	output logic [7:0] reg_rdata_o,
	// Transmit events, same clock
	input wire logic packet_sent_i,
	input wire logic frame_end_sent_i,
	input wire logic link_idle_i,
	input wire logic tx_error_i,
	// Asynchronous inputs
	input wire logic lane_bit_clk_i,
	input wire logic [CTP_NUM_RX-1:0] rx_port_enable_i,
	input wire logic [CTP_NUM_RX-1:0] rx_video_valid_i,
	// Lane control
	output logic tx_enable_o,
	output logic [3:0] lanes_active_o,
	output logic data_lp00_o,
	output logic clk_lp00_o,
	output logic clock_continuous_o,
	output logic hs_data_allowed_o,
	output logic skew_active_o,
	output logic skew_bit_o,
	output logic pass_o
);
	// ==========================================================
	// Input synchronisers
	logic [CTP_NUM_RX-1:0] vld_s1_ff, vld_s2_ff;
	logic [CTP_NUM_RX-1:0] pen_s1_ff, pen_s2_ff;
	logic bclk_s1_ff, bclk_s2_ff, bclk_prev_ff;
	logic bit_edge;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vld_s1_ff <= '0;
			vld_s2_ff <= '0;
			pen_s1_ff <= '0;
			pen_s2_ff <= '0;
			bclk_s1_ff <= 1'b0;
			bclk_s2_ff <= 1'b0;
			bclk_prev_ff <= 1'b0;
		end else begin
			vld_s1_ff <= rx_video_valid_i;
			vld_s2_ff <= vld_s1_ff;
			// Port enables come from another domain as well
			pen_s1_ff <= rx_port_enable_i;
			pen_s2_ff <= pen_s1_ff;
			bclk_s1_ff <= lane_bit_clk_i;
			bclk_s2_ff <= bclk_s1_ff;
			bclk_prev_ff <= bclk_s2_ff;
		end
	end
	assign bit_edge = bclk_s2_ff & ~bclk_prev_ff;

	// ==========================================================
	// Registers
	logic [7:0] sel_ff, ctl_ff, cal_ff, rdata_ff;
	logic [7:0] nxt_sel, nxt_ctl, nxt_cal, nxt_rdata;
	logic [0:0] port_wr_en;
	logic wr_ctl, wr_cal, cal_done;
	ctp_state_t st_ff, nxt_st;
	logic per_pend_ff, nxt_per_pend;

	// Single port here; a wider vector would fan one write to each copy
	assign port_wr_en = sel_ff[CTP_BIT_WRITE_PORT0 +: 1];
	assign wr_ctl = reg_req_i.wr && reg_req_i.addr == CTP_OFS_OUTPUT_CTRL &&
		port_wr_en[0];
	assign wr_cal = reg_req_i.wr && reg_req_i.addr == CTP_OFS_CALIB_CTRL &&
		port_wr_en[0];

	always_comb begin
		nxt_sel = sel_ff;
		nxt_ctl = ctl_ff;
		nxt_cal = cal_ff;
		nxt_rdata = rdata_ff;
		if (reg_req_i.wr && reg_req_i.addr == CTP_OFS_PORT_SELECT) begin
			nxt_sel = reg_req_i.wdata & CTP_MSK_PORT_SELECT;
		end
		if (wr_ctl) begin
			nxt_ctl = reg_req_i.wdata & CTP_MSK_OUTPUT_CTRL;
		end
		// A write of one in the completion cycle keeps the request
		if (cal_done && st_ff == CTP_ST_CAL) begin
			nxt_cal[CTP_BIT_CAL_SINGLE] = 1'b0;
		end
		if (wr_cal) begin
			nxt_cal = reg_req_i.wdata & CTP_MSK_CALIB_CTRL;
			if (cal_done && st_ff == CTP_ST_CAL &&
				!reg_req_i.wdata[CTP_BIT_CAL_SINGLE]) begin
				nxt_cal[CTP_BIT_CAL_SINGLE] = 1'b0;
			end
		end
		if (reg_req_i.rd) begin
			if (reg_req_i.addr == CTP_OFS_PORT_SELECT) begin
				nxt_rdata = sel_ff;
			end else if (reg_req_i.addr == CTP_OFS_OUTPUT_CTRL) begin
				nxt_rdata = ctl_ff;
			end else if (reg_req_i.addr == CTP_OFS_CALIB_CTRL) begin
				nxt_rdata = cal_ff;
			end else begin
				nxt_rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sel_ff <= CTP_RST_PORT_SELECT;
			ctl_ff <= CTP_RST_OUTPUT_CTRL;
			cal_ff <= CTP_RST_CALIB_CTRL;
			rdata_ff <= 8'h00;
		end else begin
			sel_ff <= nxt_sel;
			ctl_ff <= nxt_ctl;
			cal_ff <= nxt_cal;
			rdata_ff <= nxt_rdata;
		end
	end
	assign reg_rdata_o = rdata_ff;

	// ==========================================================
	// Lane, stop state and continuous clock
	logic en;
	logic [1:0] lane_code, stop_code, len_code;
	logic [3:0] nxt_lanes;
	logic nxt_dlp, nxt_clp, cont_ff, nxt_cont;
	logic lanes_dlp_clp_unused;
	assign en = ctl_ff[CTP_BIT_OUT_ENABLE];
	assign lane_code = ctl_ff[CTP_POS_LANE_COUNT +: 2];
	assign stop_code = ctl_ff[CTP_POS_FORCED_STOP +: 2];
	assign len_code = cal_ff[CTP_POS_CAL_LEN +: 2];

	always_comb begin
		case (lane_code)
			2'h0: nxt_lanes = 4'hF;
			2'h1: nxt_lanes = 4'h7;
			2'h2: nxt_lanes = 4'h3;
			default: nxt_lanes = 4'h1;
		endcase
		if (!en) begin
			nxt_lanes = 4'h0;
		end
		// Reserved stop code 10 behaves as normal operation
		nxt_dlp = en && (stop_code == CTP_STOP_DATA ||
			stop_code == CTP_STOP_ALL);
		nxt_clp = en && stop_code == CTP_STOP_ALL;
		nxt_cont = cont_ff;
		if (!en || !ctl_ff[CTP_BIT_CONT_CLOCK]) begin
			nxt_cont = 1'b0;
		end else if (packet_sent_i) begin
			nxt_cont = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lanes_active_o <= 4'h0;
			data_lp00_o <= 1'b0;
			clk_lp00_o <= 1'b0;
			cont_ff <= 1'b0;
			tx_enable_o <= 1'b0;
		end else begin
			lanes_active_o <= nxt_lanes;
			data_lp00_o <= nxt_dlp;
			clk_lp00_o <= nxt_clp;
			cont_ff <= nxt_cont;
			tx_enable_o <= en;
		end
	end
	assign clock_continuous_o = cont_ff;

	// ==========================================================
	// Skew-calibration sequencer
	logic [15:0] len_bits, bit_cnt_ff, nxt_bit_cnt;
	logic cal_req, cal_bits_done;
	always_comb begin
		case (len_code)
			2'h0: len_bits = CTP_CAL_LEN_0 >> CAL_LEN_SHIFT;
			2'h1: len_bits = CTP_CAL_LEN_1 >> CAL_LEN_SHIFT;
			2'h2: len_bits = CTP_CAL_LEN_2 >> CAL_LEN_SHIFT;
			default: len_bits = CTP_CAL_LEN_3 >> CAL_LEN_SHIFT;
		endcase
	end
	assign cal_bits_done = bit_edge && bit_cnt_ff == len_bits - 16'h0001;
	assign cal_done = cal_bits_done;
	// One sequence serves both pending kinds
	assign cal_req = cal_ff[CTP_BIT_CAL_SINGLE] | per_pend_ff;

	always_comb begin
		nxt_st = st_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_per_pend = per_pend_ff;
		if (frame_end_sent_i && cal_ff[CTP_BIT_CAL_PERIODIC]) begin
			nxt_per_pend = 1'b1;
		end else if (st_ff == CTP_ST_CAL && cal_bits_done) begin
			nxt_per_pend = 1'b0;
		end
		if (!cal_ff[CTP_BIT_CAL_PERIODIC]) begin
			nxt_per_pend = 1'b0;
		end
		if ((st_ff == CTP_ST_INIT || st_ff == CTP_ST_CAL) && bit_edge) begin
			nxt_bit_cnt = bit_cnt_ff + 16'h0001;
		end
		case (st_ff)
			CTP_ST_OFF: begin
				nxt_bit_cnt = 16'h0000;
				if (en && ctl_ff[CTP_BIT_INIT_CAL]) begin
					nxt_st = CTP_ST_INIT;
				end else if (en) begin
					nxt_st = CTP_ST_RUN;
				end
			end
			CTP_ST_INIT: begin
				if (cal_bits_done) begin
					nxt_st = CTP_ST_RUN;
				end
			end
			CTP_ST_RUN: begin
				nxt_bit_cnt = 16'h0000;
				if (cal_req && link_idle_i) begin
					nxt_st = CTP_ST_CAL;
				end
			end
			CTP_ST_CAL: begin
				if (cal_bits_done) begin
					nxt_st = CTP_ST_RUN;
				end
			end
			default: nxt_st = CTP_ST_OFF;
		endcase
		if (!en) begin
			nxt_st = CTP_ST_OFF;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= CTP_ST_OFF;
			bit_cnt_ff <= 16'h0000;
			per_pend_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			bit_cnt_ff <= nxt_bit_cnt;
			per_pend_ff <= nxt_per_pend;
		end
	end
	assign skew_active_o = st_ff == CTP_ST_INIT || st_ff == CTP_ST_CAL;
	assign hs_data_allowed_o = st_ff == CTP_ST_RUN;
	assign skew_bit_o = skew_active_o &
		(bit_cnt_ff[0] ^ cal_ff[CTP_BIT_PATTERN_INV]);

	// ==========================================================
	// Pass indication
	logic any_ok, all_ok, nxt_pass, pass_ff;
	logic [CTP_NUM_RX-1:0] ok_vec;
	assign ok_vec = pen_s2_ff & vld_s2_ff;
	assign any_ok = |ok_vec;
	assign all_ok = |pen_s2_ff && ok_vec == pen_s2_ff;
	assign nxt_pass = en && !tx_error_i &&
		(cal_ff[CTP_BIT_PASS_MODE] ? all_ok : any_ok);
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pass_ff <= 1'b0;
		end else begin
			pass_ff <= nxt_pass;
		end
	end
	assign pass_o = pass_ff;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_wr_block;
		reg_req_i.wr && reg_req_i.addr == CTP_OFS_OUTPUT_CTRL && !sel_ff[0]
			|=> $stable(ctl_ff);
	endproperty
	a_wr_block: assert property (p_wr_block)
		else $error("blocked write changed control");
	property p_one_lane;
		en && lane_code == 2'h3 |=> lanes_active_o == 4'h1;
	endproperty
	a_one_lane: assert property (p_one_lane)
		else $error("lane code 11 not one lane");
	property p_data_stop;
		en && stop_code == CTP_STOP_DATA |=> data_lp00_o && !clk_lp00_o;
	endproperty
	a_data_stop: assert property (p_data_stop)
		else $error("data-only stop wrong");
	property p_cont_after_pkt;
		$rose(clock_continuous_o) |-> $past(packet_sent_i);
	endproperty
	a_cont_after_pkt: assert property (p_cont_after_pkt)
		else $error("continuous clock before packet");
	property p_off;
		!en ##1 !en |-> !tx_enable_o && lanes_active_o == 4'h0;
	endproperty
	a_off: assert property (p_off)
		else $error("output active while disabled");
	property p_first_bit;
		$rose(skew_active_o) |-> skew_bit_o == cal_ff[CTP_BIT_PATTERN_INV];
	endproperty
	a_first_bit: assert property (p_first_bit)
		else $error("pattern first bit wrong");
	property p_single_clear;
		$fell(cal_ff[CTP_BIT_CAL_SINGLE]) |->
			$past(wr_cal) || $past(st_ff == CTP_ST_CAL && cal_bits_done);
	endproperty
	a_single_clear: assert property (p_single_clear)
		else $error("single request cleared early");
	property p_init_no_hs;
		st_ff == CTP_ST_INIT |-> !hs_data_allowed_o && skew_active_o;
	endproperty
	a_init_no_hs: assert property (p_init_no_hs)
		else $error("data allowed during initial calibration");
	property p_err_pass;
		tx_error_i |=> !pass_o;
	endproperty
	a_err_pass: assert property (p_err_pass)
		else $error("pass held through error");
	property p_all_mode;
		en && cal_ff[CTP_BIT_PASS_MODE] && !tx_error_i && !all_ok
			|=> !pass_o;
	endproperty
	a_all_mode: assert property (p_all_mode)
		else $error("pass in all mode with a port missing");
	c_init: cover property (st_ff == CTP_ST_INIT ##1 st_ff == CTP_ST_RUN);
	c_single: cover property ($fell(cal_ff[CTP_BIT_CAL_SINGLE]));
	c_periodic: cover property (frame_end_sent_i ##[1:20] st_ff == CTP_ST_CAL);
	c_pass: cover property ($rose(pass_o));
endmodule // ctp_tx_port_ctrl

/* File: ctp_rx_model.sv */
/*
 * Behavioural model of the downstream camera-serial receiver that watches
 * the skew-calibration lane output of the transmit port control.
 * Assumes the lane outputs are sampled on the transmit port clock.
 */
`timescale 1ns/1ns
module ctp_rx_model
	import ctp_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Lane observation
	input wire logic skew_active_i,
	input wire logic skew_bit_i,
	// Findings of the last sequence
	output logic first_bit_o,
	output logic [15:0] toggles_o
);
	// ==========================================================
	// Pattern capture
	logic act_ff;
	logic bit_ff;

	// The final bit edge ends the sequence, so a sequence of L bits
	// shows L-1 changes while active
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			act_ff <= 1'b0;
			bit_ff <= 1'b0;
			first_bit_o <= 1'b0;
			toggles_o <= 16'h0000;
		end else begin
			act_ff <= skew_active_i;
			bit_ff <= skew_bit_i;
			if (skew_active_i && !act_ff) begin
				first_bit_o <= skew_bit_i;
				toggles_o <= 16'h0000;
			end else if (skew_active_i && (skew_bit_i != bit_ff)) begin
				toggles_o <= toggles_o + 16'h0001;
			end
		end
	end
endmodule // ctp_rx_model

/* File: tb_csi2_tx_port_control.sv */
/*
 * Self-checking bench for the transmit port control: register access,
 * lane and stop selection, continuous clock, calibration and pass.
 * Assumes the design is built with CAL_LEN_SHIFT set to 6.
 */
`timescale 1ns/1ns
module tb_csi2_tx_port_control
	import ctp_pkg::*;
;
	// ==========================================================
	// Signals
	localparam int SHIFT = 6;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	ctp_reg_req_t req = '0;
	logic [7:0] rdata;
	logic pkt = 1'b0;
	logic fe = 1'b0;
	logic link_idle = 1'b0;
	logic tx_err = 1'b0;
	logic bit_clk = 1'b0;
	logic [3:0] rx_en = 4'h3;
	logic [3:0] rx_valid = 4'h0;
	logic tx_en, d_lp, c_lp, cont, hs, skew_act, skew_bit, pass;
	logic [3:0] lanes;
	logic first_bit;
	logic [15:0] toggles;
	logic [15:0] lens [4];
	int err_count = 0;
	int n_tests = 0;

	always #20 clk_i = ~clk_i;
	// Offset keeps the bit clock out of phase with clk_i
	initial begin
		#7;
		forever #160 bit_clk = ~bit_clk;
	end

	ctp_tx_port_ctrl #(.CAL_LEN_SHIFT(SHIFT)) i_ctp_tx_port_ctrl (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_req_i(req),
		.reg_rdata_o(rdata), .packet_sent_i(pkt), .frame_end_sent_i(fe),
		.link_idle_i(link_idle), .tx_error_i(tx_err),
		.lane_bit_clk_i(bit_clk), .rx_port_enable_i(rx_en),
		.rx_video_valid_i(rx_valid), .tx_enable_o(tx_en),
		.lanes_active_o(lanes), .data_lp00_o(d_lp), .clk_lp00_o(c_lp),
		.clock_continuous_o(cont), .hs_data_allowed_o(hs),
		.skew_active_o(skew_act), .skew_bit_o(skew_bit), .pass_o(pass)
	);
	ctp_rx_model i_ctp_rx_model (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .skew_active_i(skew_act),
		.skew_bit_i(skew_bit), .first_bit_o(first_bit),
		.toggles_o(toggles)
	);

	// ==========================================================
	// Tasks
	task automatic chk(input string what, input logic [15:0] seen,
			input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cyc(1);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		cyc(1);
		req.wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		cyc(1);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		cyc(1);
		req.rd = 1'b0;
		cyc(1);
		chk("rdata", 16'(rdata), 16'(e));
	endtask

	// Waits for one calibration sequence to start and finish
	task automatic run_cal();
		int k;
		k = 0;
		while (skew_act !== 1'b1 && k < 200) begin
			cyc(1);
			k++;
		end
		chk("cal_start", 16'(skew_act), 16'h0001);
		while (skew_act !== 1'b0 && k < 6000) begin
			cyc(1);
			k++;
		end
		chk("cal_done", 16'(k < 6000), 16'h0001);
	endtask

	task automatic summarize();
		$display("counts: %0d checks, %0d mismatches", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ==========================================================
	// Watchdog
	initial begin
		#1600000;
		err_count++;
		summarize();
	end

	// ==========================================================
	// Tests
	initial begin
		lens = '{CTP_CAL_LEN_0 >> SHIFT, CTP_CAL_LEN_1 >> SHIFT,
			CTP_CAL_LEN_2 >> SHIFT, CTP_CAL_LEN_3 >> SHIFT};
		repeat (2) @(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
		rd(CTP_OFS_PORT_SELECT, CTP_RST_PORT_SELECT);
		rd(CTP_OFS_OUTPUT_CTRL, CTP_RST_OUTPUT_CTRL);
		rd(CTP_OFS_CALIB_CTRL, CTP_RST_CALIB_CTRL);
		wr(CTP_OFS_OUTPUT_CTRL, 8'h01);
		cyc(3);
		chk("tx_en_blocked", 16'(tx_en), 16'h0000);
		rd(CTP_OFS_OUTPUT_CTRL, 8'h00);
		wr(CTP_OFS_PORT_SELECT, 8'hFF);
		rd(CTP_OFS_PORT_SELECT, 8'h01);
		wr(8'h40, 8'h5A);
		rd(8'h40, 8'h00);
		$display("test registers done");
		// Lane rate taken as the top rate, so initial calibration is on
		wr(CTP_OFS_OUTPUT_CTRL, 8'hC1);
		cyc(3);
		chk("init_active", 16'(skew_act), 16'h0001);
		chk("hs_blocked", 16'(hs), 16'h0000);
		run_cal();
		chk("hs_after", 16'(hs), 16'h0001);
		chk("init_first", 16'(first_bit), 16'h0000);
		chk("init_bits", toggles, lens[0] - 16'h0001);
		rd(CTP_OFS_OUTPUT_CTRL, 8'h41);
		$display("test initial calibration done");
		for (int c = 0; c < 4; c++) begin
			wr(CTP_OFS_OUTPUT_CTRL, 8'(c << 4) | 8'h01);
			cyc(3);
			chk("lanes", 16'(lanes), 16'(4'hF >> c));
			wr(CTP_OFS_OUTPUT_CTRL, 8'(c << 2) | 8'h01);
			cyc(3);
			chk("data_lp00", 16'(d_lp), 16'(c == 1 || c == 3));
			chk("clk_lp00", 16'(c_lp), 16'(c == 3));
		end
		wr(CTP_OFS_OUTPUT_CTRL, 8'h03);
		cyc(4);
		chk("cont_early", 16'(cont), 16'h0000);
		pkt = 1'b1;
		cyc(1);
		pkt = 1'b0;
		cyc(3);
		chk("cont_run", 16'(cont), 16'h0001);
		$display("test lanes and clock done");
		for (int c = 0; c < 4; c++) begin
			link_idle = 1'b0;
			wr(CTP_OFS_CALIB_CTRL, 8'(c << 4) | 8'h02 | 8'(c % 2 << 2));
			cyc(20);
			chk("idle_gate", 16'(skew_act), 16'h0000);
			link_idle = 1'b1;
			run_cal();
			chk("first_bit", 16'(first_bit), 16'(c % 2));
			chk("bits", toggles, lens[c] - 16'h0001);
			rd(CTP_OFS_CALIB_CTRL, 8'(c << 4) | 8'(c % 2 << 2));
		end
		$display("test single calibration done");
		wr(CTP_OFS_CALIB_CTRL, 8'h21);
		fe = 1'b1;
		cyc(1);
		fe = 1'b0;
		run_cal();
		chk("periodic_bits", toggles, lens[2] - 16'h0001);
		link_idle = 1'b0;
		fe = 1'b1;
		cyc(1);
		fe = 1'b0;
		wr(CTP_OFS_CALIB_CTRL, 8'h23);
		link_idle = 1'b1;
		run_cal();
		cyc(60);
		chk("one_sequence", 16'(skew_act), 16'h0000);
		rd(CTP_OFS_CALIB_CTRL, 8'h21);
		$display("test periodic calibration done");
		wr(CTP_OFS_CALIB_CTRL, 8'h00);
		rx_valid = 4'h1;
		cyc(6);
		chk("pass_any", 16'(pass), 16'h0001);
		wr(CTP_OFS_CALIB_CTRL, 8'h08);
		cyc(4);
		chk("pass_all_part", 16'(pass), 16'h0000);
		rx_valid = 4'h3;
		cyc(6);
		chk("pass_all", 16'(pass), 16'h0001);
		tx_err = 1'b1;
		cyc(3);
		chk("pass_error", 16'(pass), 16'h0000);
		tx_err = 1'b0;
		wr(CTP_OFS_OUTPUT_CTRL, 8'h00);
		cyc(3);
		chk("tx_off", 16'(tx_en), 16'h0000);
		chk("lanes_off", 16'(lanes), 16'h0000);
		$display("test pass and disable done");
		summarize();
	end
endmodule // tb_csi2_tx_port_control
